// File: core/dcs_level_sync.sv
/*
 * Three-stage synchroniser for asynchronous status levels.
 * A change is taken once the second and third stages agree.
 * Assumes ref_clk domain, synchronous active-high reset.
 */
`timescale 1ns/10ps
module dcs_level_sync #(
	parameter int WIDTH = 14
) (
	// clock and control
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// levels
	dcs_sync_if.sync port
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// ==========================================================
	// synchroniser chain
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else if (clk_en) begin
			stage1 <= port.raw;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// ==========================================================
	// agreement filter, per bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic held;
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					held <= 1'b0;
				end else if (clk_en && (stage2[i] == stage3[i])) begin
					held <= stage3[i];
				end
			end
			assign port.clean[i] = held;
		end
	endgenerate
endmodule : dcs_level_sync

// File: core/dcs_regs.sv
/*
 * Control and status register group of the RF converter: lock event
 * enables and sticky flags, full-scale code and sleep, output switching
 * mode, phase comparison flags and the controller configuration.
 * Assumes a simple byte register port from the serial host front end
 * on ref_clk; controller and phase indications arrive asynchronously.
 */
`timescale 1ns/10ps

module dcs_regs
	import dcs_pkg::*;
#(
	parameter int CODE_WIDTH = 10,
	parameter int NUM_SYNC = 14
) (
	// clock, reset, enable
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// controller lock indications (asynchronous levels)
	input wire logic sync_locked_in,
	input wire logic align_locked_in,
	input wire logic receiver_locked_in,
	// phase comparison indications (asynchronous levels)
	input wire logic early_window_phase_in,
	input wire logic late_window_phase_in,
	input wire logic sync_zero_phase_in,
	input wire logic sync_quadrature_phase_in,
	// converter controls
	output logic [CODE_WIDTH-1:0] full_scale_code,
	output logic dac_output_enable,
	output logic [1:0] output_switch_mode,
	// sync controller controls
	output logic sync_controller_enable,
	output logic sync_role_select,
	output logic sync_auto_relock,
	output logic sync_flag_clear,
	output logic sync_restart,
	// receiver controller controls
	output logic receiver_controller_enable,
	output logic receiver_auto_relock,
	output logic receiver_flag_clear,
	output logic receiver_restart
);
	// ==========================================================
	// functions
	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	// ==========================================================
	// storage
	logic [NUM_EVENTS-1:0] event_enable;
	logic [NUM_EVENTS-1:0] event_status;
	logic [7:0] full_scale_low;
	logic [1:0] full_scale_top;
	logic sleep;
	logic [1:0] mode_field;
	logic sync_clear_bit;
	logic receiver_clear_bit;
	logic sync_loop;
	logic receiver_loop;
	logic sync_role;
	logic sync_enable;
	logic receiver_enable;
	dcs_access_t access_state;
	logic [7:0] next_rdata;

	// ==========================================================
	// input synchronisation
	dcs_sync_if #(.WIDTH(7)) levels ();
	logic [6:0] clean;
	logic sync_locked;
	logic align_locked;
	logic receiver_locked;
	logic sync_locked_d;
	logic receiver_locked_d;

	assign levels.raw = {sync_quadrature_phase_in, sync_zero_phase_in,
		late_window_phase_in, early_window_phase_in,
		receiver_locked_in, align_locked_in, sync_locked_in};

	dcs_level_sync #(.WIDTH(7)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.port(levels)
	);

	assign clean = levels.clean;
	assign sync_locked = clean[0];
	assign align_locked = clean[1];
	assign receiver_locked = clean[2];

	// ==========================================================
	// controller event conditions
	logic [NUM_EVENTS-1:0] event_cond;
	always_comb begin
		event_cond = '0;
		event_cond[BIT_SYNC_LOST] = sync_enable && !sync_locked;
		event_cond[BIT_SYNC_LOCKED] = sync_enable && sync_locked;
		event_cond[BIT_ALIGN_LOST] = !align_locked;
		event_cond[BIT_ALIGN_LOCKED] = align_locked;
		event_cond[BIT_RECEIVER_LOST] = receiver_enable && !receiver_locked;
		event_cond[BIT_RECEIVER_LOCKED] = receiver_enable && receiver_locked;
		// sync and receiver loss only count as events with auto-relock on, and for sync only on a master
		if (!(sync_loop && sync_role)) begin
			event_cond[BIT_SYNC_LOST] = 1'b0;
		end
		if (!receiver_loop) begin
			event_cond[BIT_RECEIVER_LOST] = 1'b0;
		end
	end

	// ==========================================================
	// register port access
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			access_state <= DCS_IDLE;
		end else if (clk_en) begin
			case (access_state)
				DCS_IDLE: begin
					if (reg_wr) begin
						access_state <= DCS_WRITE;
					end else if (reg_rd) begin
						access_state <= DCS_READ;
					end
				end
				DCS_WRITE: begin
					access_state <= DCS_IDLE;
				end
				DCS_READ: begin
					access_state <= DCS_IDLE;
				end
				default: begin
					access_state <= DCS_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// enables: write-only, zero clears the status bit
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			event_enable <= RST_LOCK_EVENT_ENABLE[NUM_EVENTS-1:0];
		end else if (clk_en && reg_wr &&
			hit(reg_addr, ADDR_LOCK_EVENT_ENABLE)) begin
			event_enable <= reg_wdata[NUM_EVENTS-1:0];
		end
	end

	// ==========================================================
	// sticky status
	genvar e;
	generate
		for (e = 0; e < NUM_EVENTS; e++) begin : g_event
			always_ff @(posedge ref_clk) begin
				if (sys_rst) begin
					event_status[e] <= 1'b0;
				end else if (clk_en) begin
					if (event_enable[e] && event_cond[e]) begin
						event_status[e] <= 1'b1;
					end else if (!event_enable[e]) begin
						event_status[e] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// full-scale code, sleep and mode
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			full_scale_low <= RST_FULL_SCALE_LOW;
			full_scale_top <= RST_FULL_SCALE_TOP;
			sleep <= RST_SLEEP;
			mode_field <= RST_OUTPUT_SWITCH_MODE;
		end else if (clk_en && reg_wr) begin
			if (hit(reg_addr, ADDR_FULL_SCALE_LOW)) begin
				full_scale_low <= reg_wdata;
			end
			if (hit(reg_addr, ADDR_FULL_SCALE_HIGH_SLEEP)) begin
				full_scale_top <= reg_wdata[1:0];
				sleep <= reg_wdata[BIT_SLEEP];
			end
			if (hit(reg_addr, ADDR_OUTPUT_SWITCH_MODE)) begin
				mode_field <= reg_wdata[1:0];
			end
		end
	end

	// ==========================================================
	// controller configuration
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_clear_bit <= RST_RECEIVER_CONTROLLER_CONFIG[BIT_SYNC_FLAG_CLEAR];
			sync_loop <= RST_RECEIVER_CONTROLLER_CONFIG[BIT_SYNC_AUTO_RELOCK];
			sync_role <= RST_RECEIVER_CONTROLLER_CONFIG[BIT_SYNC_ROLE];
			sync_enable <= RST_RECEIVER_CONTROLLER_CONFIG[BIT_SYNC_ENABLE];
			receiver_clear_bit <=
				RST_RECEIVER_CONTROLLER_CONFIG[BIT_RECEIVER_FLAG_CLEAR];
			receiver_loop <=
				RST_RECEIVER_CONTROLLER_CONFIG[BIT_RECEIVER_AUTO_RELOCK];
			receiver_enable <=
				RST_RECEIVER_CONTROLLER_CONFIG[BIT_RECEIVER_ENABLE];
		end else if (clk_en && reg_wr &&
			hit(reg_addr, ADDR_RECEIVER_CONTROLLER_CONFIG)) begin
			sync_clear_bit <= reg_wdata[BIT_SYNC_FLAG_CLEAR];
			sync_loop <= reg_wdata[BIT_SYNC_AUTO_RELOCK];
			sync_role <= reg_wdata[BIT_SYNC_ROLE];
			sync_enable <= reg_wdata[BIT_SYNC_ENABLE];
			receiver_clear_bit <= reg_wdata[BIT_RECEIVER_FLAG_CLEAR];
			receiver_loop <= reg_wdata[BIT_RECEIVER_AUTO_RELOCK];
			receiver_enable <= reg_wdata[BIT_RECEIVER_ENABLE];
		end
	end

	// ==========================================================
	// read mux
	always_comb begin
		next_rdata = 8'h00;
		case (reg_addr)
			ADDR_LOCK_EVENT_STATUS: begin
				next_rdata[NUM_EVENTS-1:0] = event_status;
			end
			ADDR_FULL_SCALE_LOW: begin
				next_rdata = full_scale_low;
			end
			ADDR_FULL_SCALE_HIGH_SLEEP: begin
				next_rdata[1:0] = full_scale_top;
				next_rdata[BIT_SLEEP] = sleep;
			end
			ADDR_OUTPUT_SWITCH_MODE: begin
				next_rdata[1:0] = mode_field;
			end
			ADDR_DATA_CLOCK_PHASE_STATUS: begin
				next_rdata[BIT_EARLY_PHASE] = clean[3];
				next_rdata[BIT_LATE_PHASE] = clean[4];
			end
			ADDR_SYNC_INPUT_PHASE_STATUS: begin
				next_rdata[BIT_SYNC_ZERO_PHASE] = clean[5];
				next_rdata[BIT_SYNC_QUAD_PHASE] = clean[6];
			end
			ADDR_RECEIVER_CONTROLLER_CONFIG: begin
				// clear bits are write-only and read as zero
				next_rdata[BIT_SYNC_AUTO_RELOCK] = sync_loop;
				next_rdata[BIT_SYNC_ROLE] = sync_role;
				next_rdata[BIT_SYNC_ENABLE] = sync_enable;
				next_rdata[BIT_RECEIVER_AUTO_RELOCK] = receiver_loop;
				next_rdata[BIT_RECEIVER_ENABLE] = receiver_enable;
			end
			default: begin
				// write-only and unmapped addresses read zero
				next_rdata = 8'h00;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else if (clk_en) begin
			reg_rvalid <= (access_state == DCS_IDLE) && reg_rd && !reg_wr;
			if ((access_state == DCS_IDLE) && reg_rd && !reg_wr) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// ==========================================================
	// control outputs, all registered
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			full_scale_code <= '0;
			dac_output_enable <= 1'b0;
			output_switch_mode <= RST_OUTPUT_SWITCH_MODE;
			sync_controller_enable <= 1'b0;
			sync_role_select <= 1'b0;
			sync_auto_relock <= 1'b0;
			sync_flag_clear <= 1'b0;
			receiver_controller_enable <= 1'b0;
			receiver_auto_relock <= 1'b0;
			receiver_flag_clear <= 1'b0;
		end else if (clk_en) begin
			full_scale_code <= CODE_WIDTH'({full_scale_top, full_scale_low});
			dac_output_enable <= !sleep;
			output_switch_mode <= mode_field;
			sync_controller_enable <= sync_enable;
			sync_role_select <= sync_role;
			sync_auto_relock <= sync_loop && sync_role;
			sync_flag_clear <= sync_clear_bit;
			receiver_controller_enable <= receiver_enable;
			receiver_auto_relock <= receiver_loop;
			receiver_flag_clear <= receiver_clear_bit;
		end
	end

	// ==========================================================
	// restart pulses on loss of lock
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_locked_d <= 1'b0;
			receiver_locked_d <= 1'b0;
			sync_restart <= 1'b0;
			receiver_restart <= 1'b0;
		end else if (clk_en) begin
			sync_locked_d <= sync_locked;
			receiver_locked_d <= receiver_locked;
			sync_restart <= sync_enable && sync_loop && sync_role &&
				sync_locked_d && !sync_locked;
			receiver_restart <= receiver_enable && receiver_loop &&
				receiver_locked_d && !receiver_locked;
		end
	end
endmodule : dcs_regs

// File: include/dcs_pkg.sv
/*
 * Package for the converter control/status register group: offsets,
 * field positions, reset values and mode encodings.
 * Assumes an 8-bit register port with 8-bit addresses.
 */
package dcs_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_LOCK_EVENT_ENABLE = 8'h03;
	localparam logic [7:0] ADDR_LOCK_EVENT_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FULL_SCALE_LOW = 8'h06;
	localparam logic [7:0] ADDR_FULL_SCALE_HIGH_SLEEP = 8'h07;
	localparam logic [7:0] ADDR_OUTPUT_SWITCH_MODE = 8'h08;
	localparam logic [7:0] ADDR_DATA_CLOCK_PHASE_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_SYNC_INPUT_PHASE_STATUS = 8'h0d;
	localparam logic [7:0] ADDR_RECEIVER_CONTROLLER_CONFIG = 8'h10;

	// ==========================================================
	// lock event bit positions (enable and status share them)
	localparam int BIT_SYNC_LOST = 5;
	localparam int BIT_SYNC_LOCKED = 4;
	localparam int BIT_ALIGN_LOST = 3;
	localparam int BIT_ALIGN_LOCKED = 2;
	localparam int BIT_RECEIVER_LOST = 1;
	localparam int BIT_RECEIVER_LOCKED = 0;
	localparam int NUM_EVENTS = 6;

	// ==========================================================
	// other field positions
	localparam int BIT_SLEEP = 7;
	localparam int BIT_EARLY_PHASE = 2;
	localparam int BIT_LATE_PHASE = 0;
	localparam int BIT_SYNC_QUAD_PHASE = 5;
	localparam int BIT_SYNC_ZERO_PHASE = 4;
	localparam int BIT_SYNC_FLAG_CLEAR = 7;
	localparam int BIT_SYNC_AUTO_RELOCK = 6;
	localparam int BIT_SYNC_ROLE = 5;
	localparam int BIT_SYNC_ENABLE = 4;
	localparam int BIT_RECEIVER_FLAG_CLEAR = 2;
	localparam int BIT_RECEIVER_AUTO_RELOCK = 1;
	localparam int BIT_RECEIVER_ENABLE = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_LOCK_EVENT_ENABLE = 8'h00;
	localparam logic [7:0] RST_FULL_SCALE_LOW = 8'h00;
	localparam logic [1:0] RST_FULL_SCALE_TOP = 2'h2;
	localparam logic RST_SLEEP = 1'b0;
	localparam logic [1:0] RST_OUTPUT_SWITCH_MODE = 2'h0;
	localparam logic [7:0] RST_RECEIVER_CONTROLLER_CONFIG = 8'h42;

	// ==========================================================
	// output switching modes
	typedef enum logic [1:0] {
		DCS_MODE_BASEBAND = 2'h0,
		DCS_MODE_RETURN_ZERO = 2'h1,
		DCS_MODE_MIX = 2'h2,
		DCS_MODE_RESERVED = 2'h3
	} dcs_switch_mode_t;

	// register port access states
	typedef enum logic [1:0] {
		DCS_IDLE = 2'b00,
		DCS_WRITE = 2'b01,
		DCS_READ = 2'b11
	} dcs_access_t;
endpackage : dcs_pkg

// File: include/dcs_sync_if.sv
/*
 * Carrier for the input synchroniser: raw asynchronous levels in,
 * qualified levels out.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
interface dcs_sync_if #(parameter int WIDTH = 14);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] clean;
	modport owner (output raw, input clean);
	modport sync (input raw, output clean);
endinterface : dcs_sync_if

// File: tb/dcs_host_model.sv
/*
 * Register host model: byte writes one idle cycle apart, reads two idle cycles apart.
 * Assumes a read answer shows one edge after the strobe is taken.
 */
`timescale 1ns/10ps
module dcs_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// ==========================================================
	// bus cycles
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// released lines invert so a stale value never passes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// strobe is a one-cycle pulse; the answer is taken at the edge
	// where read valid is sampled high, one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge ref_clk);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask : rd
	task automatic clear_flags(input logic [7:0] cfg);
		wr(8'h10, cfg | 8'h84);
		wr(8'h10, cfg & 8'h7b);
	endtask : clear_flags
endmodule : dcs_host_model

// File: tb/dcs_regs_monitor.sv
/*
 * Checker for the converter register group, bound to dcs_regs.
 * Assumes writes spaced by an idle cycle and clk_en held high.
 */
`timescale 1ns/10ps
module dcs_regs_monitor
	import dcs_pkg::*;
#(
	parameter int CODE_WIDTH = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	// controls
	input wire logic [CODE_WIDTH-1:0] full_scale_code,
	input wire logic dac_output_enable,
	input wire logic [1:0] output_switch_mode,
	input wire logic sync_controller_enable,
	input wire logic sync_role_select,
	input wire logic sync_auto_relock,
	input wire logic sync_flag_clear,
	input wire logic sync_restart,
	input wire logic receiver_controller_enable,
	input wire logic receiver_auto_relock,
	input wire logic receiver_flag_clear,
	input wire logic receiver_restart
);
	// ==========================================================
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire logic wr_on = reg_wr && clk_en;
	wire logic wr_lo = wr_on && reg_addr == ADDR_FULL_SCALE_LOW;
	wire logic wr_hi = wr_on && reg_addr == ADDR_FULL_SCALE_HIGH_SLEEP;
	wire logic wr_md = wr_on && reg_addr == ADDR_OUTPUT_SWITCH_MODE;
	wire logic wr_cf = wr_on && reg_addr == ADDR_RECEIVER_CONTROLLER_CONFIG;
	wire logic [6:0] cf_pins = {sync_flag_clear, sync_auto_relock,
		sync_role_select, sync_controller_enable, receiver_flag_clear,
		receiver_auto_relock, receiver_controller_enable};

	rvalid_pulse_a: assert property (reg_rvalid |=> !reg_rvalid)
		else $error("read valid longer than one cycle");
	wo_read_a: assert property (reg_rvalid && $past(reg_addr) == 8'h03
		|-> reg_rdata == 8'h00) else $error("enable register read not zero");
	code_low_a: assert property (wr_lo
		|-> ##2 full_scale_code[7:0] == $past(reg_wdata, 2))
		else $error("code low byte not applied");
	code_high_a: assert property (wr_hi
		|-> ##2 full_scale_code[9:8] == $past(reg_wdata[1:0], 2))
		else $error("code top bits not applied");
	sleep_out_a: assert property (wr_hi
		|-> ##2 dac_output_enable == !$past(reg_wdata[7], 2))
		else $error("sleep bit not applied");
	mode_out_a: assert property (wr_md
		|-> ##2 output_switch_mode == $past(reg_wdata[1:0], 2))
		else $error("switch mode not applied");
	config_out_a: assert property (wr_cf ##2 1'b1
		|-> cf_pins == {$past(reg_wdata[7], 2),
		$past(reg_wdata[6] & reg_wdata[5], 2), $past(reg_wdata[5:4], 2),
		$past(reg_wdata[2:0], 2)}) else $error("config not applied");
	frozen_out_a: assert property (!clk_en && !sys_rst
		|=> $stable(full_scale_code) && $stable(output_switch_mode)
		&& $stable(dac_output_enable))
		else $error("outputs moved with clock enable low");
	sync_restart_a: assert property (sync_restart
		|-> sync_controller_enable && sync_auto_relock)
		else $error("sync restart without master loop");
	rcv_restart_a: assert property (receiver_restart
		|-> receiver_controller_enable && receiver_auto_relock)
		else $error("receiver restart without loop");

	cover property (sync_restart);
	cover property (receiver_restart);
	cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule : dcs_regs_monitor

bind dcs_regs dcs_regs_monitor #(.CODE_WIDTH(CODE_WIDTH)) mon_u (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.full_scale_code(full_scale_code),
	.dac_output_enable(dac_output_enable),
	.output_switch_mode(output_switch_mode),
	.sync_controller_enable(sync_controller_enable),
	.sync_role_select(sync_role_select),
	.sync_auto_relock(sync_auto_relock), .sync_flag_clear(sync_flag_clear),
	.sync_restart(sync_restart),
	.receiver_controller_enable(receiver_controller_enable),
	.receiver_auto_relock(receiver_auto_relock),
	.receiver_flag_clear(receiver_flag_clear),
	.receiver_restart(receiver_restart)
);

// File: tb/tb.sv
/*
 * Self-checking bench for dcs_regs with the host model.
 * Assumes the lock and phase levels may be driven at any edge.
 */
`timescale 1ns/10ps
module tb
	import dcs_pkg::*;
;
	// ==========================================================
	// signals
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic [2:0] lk = 3'h0;
	logic [3:0] ph = 4'h0;
	logic seen_sr = 1'b0;
	logic seen_rr = 1'b0;
	int num_errors = 0;
	int n_compared = 0;
	int i;
	logic [7:0] d, v;
	logic [9:0] c;
	logic [7:0] ra [7] = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h10, 8'h05};
	logic [7:0] re [7] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h42, 8'h00};
	wire logic reg_wr, reg_rd, reg_rvalid, dac_output_enable;
	wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
	wire logic [9:0] full_scale_code;
	wire logic [1:0] output_switch_mode;
	wire logic s_en, s_role, s_loop, s_clr, s_rst, r_en, r_loop, r_clr, r_rst;
	wire logic [9:0] cfg_pins = {3'h0, s_clr, s_role, s_en, s_loop, r_clr,
		r_loop, r_en};

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (s_rst === 1'b1) seen_sr <= 1'b1;
		if (r_rst === 1'b1) seen_rr <= 1'b1;
	end

	dcs_host_model h_u (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	dcs_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sync_locked_in(lk[2]), .align_locked_in(lk[1]),
		.receiver_locked_in(lk[0]), .early_window_phase_in(ph[0]),
		.late_window_phase_in(ph[1]), .sync_zero_phase_in(ph[2]),
		.sync_quadrature_phase_in(ph[3]), .full_scale_code(full_scale_code),
		.dac_output_enable(dac_output_enable),
		.output_switch_mode(output_switch_mode), .sync_controller_enable(s_en),
		.sync_role_select(s_role), .sync_auto_relock(s_loop),
		.sync_flag_clear(s_clr), .sync_restart(s_rst),
		.receiver_controller_enable(r_en), .receiver_auto_relock(r_loop),
		.receiver_flag_clear(r_clr), .receiver_restart(r_rst));

	// ==========================================================
	// expectations and checks
	function automatic logic [9:0] cfg_exp(input logic [7:0] x);
		return {3'h0, x[7], x[5], x[4], x[6] & x[5], x[2], x[1], x[0]};
	endfunction : cfg_exp
	function automatic logic [7:0] ph_exp(input logic [3:0] p, input logic s);
		return s ? {2'h0, p[3], p[2], 4'h0} : {5'h0, p[0], 1'b0, p[1]};
	endfunction : ph_exp
	task automatic chk_reg(input string n, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk_reg
	task automatic chk_pin(input string n, input logic [9:0] e, g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk_pin
	task automatic settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// a normal run is near 260 cycles, so 10000 means a hang
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end

	// ==========================================================
	// tests
	initial begin
		void'($urandom(11));
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		settle();
		chk_pin("code", 10'h200, full_scale_code);
		chk_pin("out_en", 10'h1, 10'(dac_output_enable));
		chk_pin("config", cfg_exp(8'h42), cfg_pins);
		for (i = 0; i < 7; i++) begin
			h_u.rd(ra[i], d);
			chk_reg("reset", re[i], d);
		end
		for (i = 0; i < 6; i++) begin
			c = (i == 0) ? 10'h0 : (i == 1) ? 10'h3ff : 10'($urandom);
			v = {i[0], 5'h0, c[9:8]};
			h_u.wr(ADDR_FULL_SCALE_LOW, c[7:0]);
			h_u.wr(ADDR_FULL_SCALE_HIGH_SLEEP, v);
			settle();
			chk_pin("code", c, full_scale_code);
			chk_pin("out_en", 10'(!v[7]), 10'(dac_output_enable));
			h_u.rd(ADDR_FULL_SCALE_HIGH_SLEEP, d);
			chk_reg("fs_high", v, d & 8'h83);
		end
		for (i = 0; i < 3; i++) begin
			h_u.wr(ADDR_OUTPUT_SWITCH_MODE, 8'(i));
			settle();
			chk_pin("mode", 10'(i), 10'(output_switch_mode));
			h_u.rd(ADDR_OUTPUT_SWITCH_MODE, d);
			chk_reg("mode", 8'(i), d);
		end
		// clock enable low: a write is not taken and outputs hold
		@(posedge ref_clk);
		clk_en <= 1'b0;
		h_u.wr(ADDR_OUTPUT_SWITCH_MODE, 8'h01);
		settle();
		chk_pin("frozen", 10'h2, 10'(output_switch_mode));
		@(posedge ref_clk);
		clk_en <= 1'b1;
		for (i = 0; i < 5; i++) begin
			v = (i == 0) ? 8'h20 : (i == 1) ? 8'h40 : 8'($urandom);
			h_u.wr(ADDR_RECEIVER_CONTROLLER_CONFIG, v);
			settle();
			chk_pin("config", cfg_exp(v), cfg_pins);
			h_u.rd(ADDR_RECEIVER_CONTROLLER_CONFIG, d);
			chk_reg("config", v & 8'h73, d);
		end
		h_u.clear_flags(8'h73);
		@(posedge ref_clk);
		lk <= 3'h7;
		repeat (10) @(posedge ref_clk);
		h_u.wr(ADDR_LOCK_EVENT_ENABLE, 8'h3f);
		settle();
		h_u.rd(ADDR_LOCK_EVENT_STATUS, d);
		chk_reg("status", 8'h15, d);
		@(posedge ref_clk);
		lk <= 3'h0;
		repeat (10) @(posedge ref_clk);
		h_u.rd(ADDR_LOCK_EVENT_STATUS, d);
		chk_reg("status", 8'h3f, d);
		chk_pin("restart", 10'h3, 10'({seen_sr, seen_rr}));
		h_u.wr(ADDR_LOCK_EVENT_ENABLE, 8'h00);
		settle();
		h_u.rd(ADDR_LOCK_EVENT_STATUS, d);
		chk_reg("status", 8'h00, d);
		h_u.wr(ADDR_LOCK_EVENT_ENABLE, 8'h3f);
		for (i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			ph <= (i == 0) ? 4'hf : 4'($urandom);
			repeat (10) @(posedge ref_clk);
			h_u.rd(ADDR_DATA_CLOCK_PHASE_STATUS, d);
			chk_reg("dci_phase", ph_exp(ph, 1'b0), d);
			h_u.rd(ADDR_SYNC_INPUT_PHASE_STATUS, d);
			chk_reg("sync_phase", ph_exp(ph, 1'b1), d);
		end
		wrap_up();
	end
endmodule : tb
